// ---- src/reset_seq_pkg.sv ----
// Purpose: Shared constants and types of the reset source sequencer.
// Assumes: ref_clk_i at 250 MHz; supervisor timers count ticks of the 31 kHz
//          low-frequency oscillator.
// Notes: Addresses are word addresses on the plain register port.
package reset_seq_pkg;

	function automatic int ceil_div(input int num, input int den);
		ceil_div = (num + den - 1) / den;
	endfunction

	localparam int CLK_PERIOD_NS = 4;

	// Register port
	localparam int ADDR_W = 16;
	localparam int DATA_W = 14;
	localparam logic [15:0] PART_IDENT_ADDR = 16'h8006;
	localparam logic [15:0] PWR_STATUS_ADDR = 16'h0001;
	localparam logic [15:0] WDT_STATUS_ADDR = 16'h0002;
	localparam logic [15:0] OSC_CONTROL_ADDR = 16'h0003;
	localparam logic [15:0] SUPV_CONTROL_ADDR = 16'h0004;

	// Part identity word layout
	localparam int PART_IDENT_LSB = 5;
	localparam int PART_IDENT_W = 9;
	localparam int SILICON_STEP_LSB = 0;
	localparam int SILICON_STEP_W = 5;

	// Power control status layout
	localparam int PCS_STK_OVF = 7;
	localparam int PCS_STK_UNF = 6;
	localparam int PCS_RI_N = 2;
	localparam int PCS_POR_N = 1;
	localparam int PCS_BOR_N = 0;
	// Watchdog status layout
	localparam int WST_TO_N = 1;
	localparam int WST_PD_N = 0;

	// Reset values
	localparam logic [3:0] FREQ_SELECT_RST = 4'h7;
	localparam logic [0:0] WDT_EN_RST = 1'h1;
	localparam logic [0:0] CFG_ERASED_BIT = 1'h1;

	// Timing
	localparam int FILTER_TIME_NS = 200;
	localparam int FILTER_CYCLES = ceil_div(FILTER_TIME_NS, CLK_PERIOD_NS);
	localparam int RESET_MIN_NS = 64;
	localparam int RESET_MIN_CYCLES = ceil_div(RESET_MIN_NS, CLK_PERIOD_NS);
	localparam int POWERUP_DELAY_TIMER_TICKS_DEF = 2048;
	localparam int WDT_TICKS_DEF = 512;
	localparam int TICK_W = 12;

	// Synchroniser lanes
	localparam int SYN_PIN = 0;
	localparam int SYN_LFO = 1;
	localparam int SYN_POR = 2;
	localparam int SYN_BOR = 3;
	localparam int SYN_LOW_POWER_BROWNOUT_MONITOR = 4;
	localparam int SYN_W = 5;

	typedef enum logic [1:0] {
		SEQ_HOLD = 2'h0,
		SEQ_DELAY = 2'h1,
		SEQ_RUN = 2'h3
	} seq_state_type;

endpackage

// ---- src/pin_glitch_filter.sv ----
// Purpose: Ignores short pulses on the synchronised reset pin level.
// Assumes: in_i already passed two flip-flops.
// Notes: The output changes only after the input held a new level for
//        FILTER_CYCLES clocks; the pin idles high.
module pin_glitch_filter
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	// Level
	input wire logic in_i,
	output logic out_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic level;
	} filt_state_type;

	filt_state_type st_reg;
	filt_state_type st_next;

	always_comb
	begin
		st_next = st_reg;
		if (in_i == st_reg.level)
			st_next.cnt = 8'h00;
		else if (st_reg.cnt == 8'(reset_seq_pkg::FILTER_CYCLES - 1))
		begin
			st_next.level = in_i;
			st_next.cnt = 8'h00;
		end
		else
			st_next.cnt = st_reg.cnt + 8'h01;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st_reg <= '{cnt: 8'h00, level: 1'h1};
		else if (clk_en_i)
			st_reg <= st_next;
	end

	assign out_o = st_reg.level;
endmodule

// ---- src/lfo_tick_timer.sv ----
// Purpose: Counts low-frequency oscillator ticks up to a limit.
// Assumes: tick_i is a one-cycle pulse on ref_clk_i.
// Notes: done_o stays high until clear_i restarts the count.
module lfo_tick_timer
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	// Control
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [11:0] limit_i,
	output logic done_o
);
	typedef struct packed {
		logic [11:0] cnt;
		logic done;
	} tmr_state_type;

	tmr_state_type st_reg;
	tmr_state_type st_next;

	always_comb
	begin
		st_next = st_reg;
		if (clear_i)
		begin
			st_next.cnt = 12'h000;
			st_next.done = 1'h0;
		end
		else if (tick_i && !st_reg.done)
		begin
			st_next.cnt = st_reg.cnt + 12'h001;
			st_next.done = (st_reg.cnt + 12'h001) >= limit_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st_reg <= '{cnt: 12'h000, done: 1'h0};
		else if (clk_en_i)
			st_reg <= st_next;
	end

	assign done_o = st_reg.done;
endmodule

// ---- src/reset_source_sequencer.sv ----
// Purpose: Combines the reset sources, records the cause and sequences the
//          release of the internal reset.
// Assumes: Analog monitors, the reset pin and the 31 kHz oscillator are
//          asynchronous; instruction and stack events are one-cycle pulses
//          on ref_clk_i.
// Notes: Status flags survive internal resets; only rst_b_i, a status register write, a watchdog clear, a power-on event or a programming exit clears them.
module reset_source_sequencer
#(
	parameter int POWERUP_DELAY_TIMER_TICKS = reset_seq_pkg::POWERUP_DELAY_TIMER_TICKS_DEF,
	parameter int WDT_TICKS = reset_seq_pkg::WDT_TICKS_DEF,
	// Arbitrary identity values
	parameter logic [8:0] PART_IDENT = 9'h0a5,
	parameter logic [4:0] SILICON_STEP = 5'h01
)
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	// Analog monitors and oscillator
	input wire logic por_req_i,
	input wire logic brown_out_reset_i,
	input wire logic low_power_brownout_monitor_i,
	input wire logic low_freq_internal_osc_i,
	// Oscillator start-up timer
	input wire logic ost_required_i,
	input wire logic ost_done_i,
	// Configuration word bits
	input wire logic low_power_brownout_cfg_i,
	input wire logic ext_reset_pin_enable_cfg_i,
	input wire logic low_voltage_program_cfg_i,
	input wire logic stack_fault_reset_enable_i,
	input wire logic powerup_delay_enable_n_i,
	// Core events
	input wire logic watchdog_clear_instr_i,
	input wire logic reset_instr_i,
	input wire logic stack_over_i,
	input wire logic stack_under_i,
	input wire logic prog_mode_exit_i,
	// Reset pin
	input wire logic ext_reset_pin_i,
	output logic ext_reset_pin_o,
	output logic ext_reset_pin_oe_o,
	input wire logic sw_pullup_en_i,
	output logic pin_pullup_en_o,
	output logic gpio_in_o,
	// Register port
	input wire logic [15:0] reg_addr_i,
	input wire logic [13:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [13:0] reg_rdata_o,
	// System
	output logic sys_reset_o,
	output logic [3:0] int_osc_freq_select_o
);
	typedef struct packed {
		logic [reset_seq_pkg::SYN_W-1:0] sync1;
		logic [reset_seq_pkg::SYN_W-1:0] sync2;
		logic lfo_last;
		reset_seq_pkg::seq_state_type state;
		logic [4:0] hold_cnt;
		logic cold_pend;
		logic por_n;
		logic bor_n;
		logic ri_n;
		logic stk_ovf;
		logic stk_unf;
		logic to_n;
		logic pd_n;
		logic wdt_en;
		logic [3:0] freq;
		logic [13:0] rdata;
	} seq_type;

	localparam logic [4:0] HOLD_LAST = 5'(reset_seq_pkg::RESET_MIN_CYCLES - 1);

	seq_type st_reg;
	seq_type st_next;
	logic pin_filt;
	logic lfo_tick;
	logic pin_fn_en;
	logic low_power_brownout_monitor_en;
	logic brown_any;
	logic pin_hold;
	logic stack_rst;
	logic wdt_done;
	logic wdt_fire;
	logic powerup_delay_timer_done;
	logic timers_ok;
	logic cold_lvl;
	logic cold_evt;
	logic warm_evt;
	logic [13:0] ident_word;

	assign lfo_tick = st_reg.sync2[reset_seq_pkg::SYN_LFO] && !st_reg.lfo_last;
	assign low_power_brownout_monitor_en = low_power_brownout_cfg_i != reset_seq_pkg::CFG_ERASED_BIT;
	assign brown_any = st_reg.sync2[reset_seq_pkg::SYN_BOR]
		|| (low_power_brownout_monitor_en && st_reg.sync2[reset_seq_pkg::SYN_LOW_POWER_BROWNOUT_MONITOR]);
	assign pin_fn_en = ext_reset_pin_enable_cfg_i || low_voltage_program_cfg_i;
	assign pin_hold = pin_fn_en && !pin_filt;
	assign stack_rst = stack_fault_reset_enable_i
		&& (stack_over_i || stack_under_i);
	assign wdt_fire = wdt_done && st_reg.state == reset_seq_pkg::SEQ_RUN;
	assign cold_lvl = st_reg.sync2[reset_seq_pkg::SYN_POR] || brown_any;
	assign cold_evt = cold_lvl || prog_mode_exit_i;
	assign warm_evt = reset_instr_i || stack_rst || wdt_fire;
	// Power-up delay is skipped when its enable bit is high
	assign timers_ok = (powerup_delay_enable_n_i || powerup_delay_timer_done)
		&& (!ost_required_i || ost_done_i);
	assign ident_word = {PART_IDENT, SILICON_STEP};

	pin_glitch_filter u_pin_filter
	(
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.in_i(st_reg.sync2[reset_seq_pkg::SYN_PIN]),
		.out_o(pin_filt)
	);

	// Restarted by any clear, any reset, or while disabled
	lfo_tick_timer u_wdt
	(
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.clear_i(watchdog_clear_instr_i || !st_reg.wdt_en
			|| st_reg.state != reset_seq_pkg::SEQ_RUN),
		.tick_i(lfo_tick),
		.limit_i(12'(WDT_TICKS)),
		.done_o(wdt_done)
	);

	// Runs only in the delay state, whatever the pin does
	lfo_tick_timer u_powerup_delay_timer
	(
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.clear_i(st_reg.state != reset_seq_pkg::SEQ_DELAY),
		.tick_i(lfo_tick),
		.limit_i(12'(POWERUP_DELAY_TIMER_TICKS)),
		.done_o(powerup_delay_timer_done)
	);

	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = {low_power_brownout_monitor_i, brown_out_reset_i,
			por_req_i, low_freq_internal_osc_i, ext_reset_pin_i};
		st_next.sync2 = st_reg.sync1;
		st_next.lfo_last = st_reg.sync2[reset_seq_pkg::SYN_LFO];
		if (cold_evt)
			st_next.cold_pend = 1'h1;

		unique case (st_reg.state)
			reset_seq_pkg::SEQ_HOLD:
			begin
				if (cold_evt || warm_evt)
					st_next.hold_cnt = 5'h00;
				else if (st_reg.hold_cnt != HOLD_LAST)
					st_next.hold_cnt = st_reg.hold_cnt + 5'h01;
				else if (st_reg.cold_pend)
					st_next.state = reset_seq_pkg::SEQ_DELAY;
				else if (!pin_hold)
					st_next.state = reset_seq_pkg::SEQ_RUN;
			end
			reset_seq_pkg::SEQ_DELAY:
			begin
				if (cold_evt || warm_evt)
				begin
					st_next.state = reset_seq_pkg::SEQ_HOLD;
					st_next.hold_cnt = 5'h00;
				end
				else if (timers_ok && !pin_hold)
				begin
					st_next.state = reset_seq_pkg::SEQ_RUN;
					st_next.cold_pend = 1'h0;
				end
			end
			reset_seq_pkg::SEQ_RUN:
			begin
				if (cold_evt || warm_evt || pin_hold)
				begin
					st_next.state = reset_seq_pkg::SEQ_HOLD;
					st_next.hold_cnt = 5'h00;
				end
			end
			default:
			begin
				st_next.state = reset_seq_pkg::SEQ_HOLD;
				st_next.hold_cnt = 5'h00;
			end
		endcase

		// Software writes first, hardware events after, so a set wins
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				reset_seq_pkg::PWR_STATUS_ADDR:
				begin
					st_next.stk_ovf = reg_wdata_i[reset_seq_pkg::PCS_STK_OVF];
					st_next.stk_unf = reg_wdata_i[reset_seq_pkg::PCS_STK_UNF];
					st_next.ri_n = reg_wdata_i[reset_seq_pkg::PCS_RI_N];
					st_next.por_n = reg_wdata_i[reset_seq_pkg::PCS_POR_N];
					st_next.bor_n = reg_wdata_i[reset_seq_pkg::PCS_BOR_N];
				end
				reset_seq_pkg::OSC_CONTROL_ADDR:
					st_next.freq = reg_wdata_i[3:0];
				reset_seq_pkg::SUPV_CONTROL_ADDR:
					st_next.wdt_en = reg_wdata_i[0];
				default:
					st_next.wdt_en = st_reg.wdt_en;
			endcase
		end

		if (watchdog_clear_instr_i)
		begin
			st_next.to_n = 1'h1;
			st_next.pd_n = 1'h1;
		end
		if (st_reg.sync2[reset_seq_pkg::SYN_POR] || prog_mode_exit_i)
		begin
			st_next.por_n = 1'h0;
			st_next.to_n = 1'h1;
			st_next.pd_n = 1'h1;
		end
		if (brown_any)
			st_next.bor_n = 1'h0;
		if (wdt_fire)
		begin
			st_next.to_n = 1'h0;
			st_next.pd_n = 1'h1;
		end
		if (reset_instr_i)
			st_next.ri_n = 1'h0;
		if (stack_over_i)
			st_next.stk_ovf = 1'h1;
		if (stack_under_i)
			st_next.stk_unf = 1'h1;
		if (st_reg.state != reset_seq_pkg::SEQ_RUN)
			st_next.freq = reset_seq_pkg::FREQ_SELECT_RST;

		st_next.rdata = 14'h0000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				reset_seq_pkg::PART_IDENT_ADDR:
					st_next.rdata = ident_word;
				reset_seq_pkg::PWR_STATUS_ADDR:
				begin
					st_next.rdata[reset_seq_pkg::PCS_STK_OVF] = st_reg.stk_ovf;
					st_next.rdata[reset_seq_pkg::PCS_STK_UNF] = st_reg.stk_unf;
					st_next.rdata[reset_seq_pkg::PCS_RI_N] = st_reg.ri_n;
					st_next.rdata[reset_seq_pkg::PCS_POR_N] = st_reg.por_n;
					st_next.rdata[reset_seq_pkg::PCS_BOR_N] = st_reg.bor_n;
				end
				reset_seq_pkg::WDT_STATUS_ADDR:
				begin
					st_next.rdata[reset_seq_pkg::WST_TO_N] = st_reg.to_n;
					st_next.rdata[reset_seq_pkg::WST_PD_N] = st_reg.pd_n;
				end
				reset_seq_pkg::OSC_CONTROL_ADDR:
					st_next.rdata[3:0] = st_reg.freq;
				reset_seq_pkg::SUPV_CONTROL_ADDR:
					st_next.rdata[0] = st_reg.wdt_en;
				default:
					st_next.rdata = 14'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st_reg <= '{sync1: '0, sync2: '0, lfo_last: 1'h0,
				state: reset_seq_pkg::SEQ_HOLD, hold_cnt: 5'h00,
				cold_pend: 1'h1, por_n: 1'h0, bor_n: 1'h1, ri_n: 1'h1,
				stk_ovf: 1'h0, stk_unf: 1'h0, to_n: 1'h1, pd_n: 1'h1,
				wdt_en: reset_seq_pkg::WDT_EN_RST,
				freq: reset_seq_pkg::FREQ_SELECT_RST, rdata: 14'h0000};
		else if (clk_en_i)
			st_reg <= st_next;
	end

	// The pin is sensed only; no reset ever pulls it low
	assign ext_reset_pin_o = 1'h0;
	assign ext_reset_pin_oe_o = 1'h0;
	// Pull-up forced on while the pin resets, else under software control
	assign pin_pullup_en_o = pin_fn_en || sw_pullup_en_i;
	assign gpio_in_o = st_reg.sync2[reset_seq_pkg::SYN_PIN];
	assign sys_reset_o = st_reg.state != reset_seq_pkg::SEQ_RUN;
	assign int_osc_freq_select_o = st_reg.freq;
	assign reg_rdata_o = st_reg.rdata;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_pin_not_driven: assert property (!ext_reset_pin_oe_o && !ext_reset_pin_o)
		else $error("reset pin driven");
	a_por_holds_reset: assert property (st_reg.sync2[reset_seq_pkg::SYN_POR] && clk_en_i
		|=> sys_reset_o && !st_reg.por_n)
		else $error("power-on request did not hold reset");
	a_low_power_brownout_monitor_flag_hold: assert property (low_power_brownout_monitor_en && clk_en_i
		&& st_reg.sync2[reset_seq_pkg::SYN_LOW_POWER_BROWNOUT_MONITOR] |=> sys_reset_o && !st_reg.bor_n)
		else $error("low-power brown-out not held or not flagged");
	a_low_power_brownout_monitor_erased_off: assert property (low_power_brownout_cfg_i == reset_seq_pkg::CFG_ERASED_BIT
		&& !st_reg.sync2[reset_seq_pkg::SYN_BOR] |-> !brown_any)
		else $error("erased configuration enabled low-power monitor");
	a_pin_enable_map: assert property (pin_fn_en
		== (ext_reset_pin_enable_cfg_i || low_voltage_program_cfg_i))
		else $error("pin enable mapping wrong");
	a_pin_low_holds: assert property (pin_hold && clk_en_i
		&& st_reg.state == reset_seq_pkg::SEQ_RUN |=> sys_reset_o)
		else $error("low reset pin did not reset");
	a_pullup_software: assert property (!pin_fn_en
		|-> pin_pullup_en_o == sw_pullup_en_i)
		else $error("pull-up not under software control");
	a_wdt_flags_set: assert property (wdt_fire && clk_en_i
		|=> !st_reg.to_n && st_reg.pd_n && sys_reset_o)
		else $error("watchdog reset flags wrong");
	a_ri_flag_clear: assert property (reset_instr_i && clk_en_i
		|=> !st_reg.ri_n && sys_reset_o)
		else $error("reset instruction flag not cleared");
	a_stack_flag_set: assert property (stack_over_i && clk_en_i
		|=> st_reg.stk_ovf)
		else $error("stack overflow flag not set");
	a_delay_only_cold: assert property (st_reg.state == reset_seq_pkg::SEQ_HOLD
		&& !st_reg.cold_pend && !cold_evt |=> st_reg.state != reset_seq_pkg::SEQ_DELAY)
		else $error("power-up delay after warm reset");
	a_release_needs_ok: assert property (st_reg.state == reset_seq_pkg::SEQ_DELAY
		##1 st_reg.state == reset_seq_pkg::SEQ_RUN |-> $past(timers_ok) && $past(!pin_hold))
		else $error("released before timers or pin ready");
	a_freq_default_load: assert property ($past(sys_reset_o) && $past(clk_en_i)
		|-> st_reg.freq == reset_seq_pkg::FREQ_SELECT_RST)
		else $error("frequency select not reloaded");
	a_ident_readback: assert property (reg_rd_i && clk_en_i
		&& reg_addr_i == reset_seq_pkg::PART_IDENT_ADDR |=> reg_rdata_o == ident_word)
		else $error("identity word read wrong");

	c_cold_release: cover property (st_reg.state == reset_seq_pkg::SEQ_DELAY
		##1 st_reg.state == reset_seq_pkg::SEQ_RUN);
	c_wdt_reset: cover property (wdt_fire);
	c_pin_reset: cover property (pin_hold && st_reg.state == reset_seq_pkg::SEQ_RUN);
	c_low_power_brownout_monitor_reset: cover property (low_power_brownout_monitor_en && st_reg.sync2[reset_seq_pkg::SYN_LOW_POWER_BROWNOUT_MONITOR]);
endmodule

// ---- bench/supply_pin_model.sv ----
// Purpose: Far side of the sequencer: supply monitors, the low-frequency
//          oscillator and the reset pin with its weak pull-up.
// Assumes: Commands from the bench change right after a rising clock edge.
// Notes: The oscillator free-runs; its period is arbitrary for the run.
module supply_pin_model
#(
	parameter int LFO_HALF = 20
)
(
	// Clock
	input wire logic ref_clk_i,
	// Commands
	input wire logic por_cmd_i,
	input wire logic bor_cmd_i,
	input wire logic low_power_brownout_monitor_cmd_i,
	input wire logic pin_low_cmd_i,
	// Device side of the pin
	input wire logic pin_drv_i,
	input wire logic pin_oe_i,
	// Levels
	output logic por_req_o,
	output logic brown_out_o,
	output logic low_power_brownout_monitor_o,
	output logic lfo_o,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int lfo_cnt = 0;
	logic low_q = 1'b0;
	initial
	begin
		por_req_o = 1'b0;
		brown_out_o = 1'b0;
		low_power_brownout_monitor_o = 1'b0;
		lfo_o = 1'b0;
	end
	// Slow clock for power-up delay and watchdog ticks
	always @(posedge ref_clk_i)
	begin
		lfo_cnt <= (lfo_cnt == LFO_HALF - 1) ? 0 : lfo_cnt + 1;
		if (lfo_cnt == LFO_HALF - 1)
			lfo_o <= ~lfo_o;
		por_req_o <= por_cmd_i;
		brown_out_o <= bor_cmd_i;
		low_power_brownout_monitor_o <= low_power_brownout_monitor_cmd_i;
		low_q <= pin_low_cmd_i;
	end
	// External party holds the pin low, else the weak pull-up wins
	assign pin_o = pin_oe_i ? pin_drv_i : !low_q;
endmodule

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: Short power-up and watchdog counts; oscillator period 40 clocks.
// Notes: A background process clears the watchdog unless a test stops it.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary identity values
	localparam logic [8:0] ID_PART = 9'h1b2;
	localparam logic [4:0] ID_STEP = 5'h0c;
	logic ref_clk_i, rst_b_i, por_cmd, bor_cmd, lp_cmd, pin_low, ost_done;
	logic lp_cfg, ext_reset_pin_enable_cfg, low_voltage_program_cfg, stk_en, powerup_delay_enable_n_n, wd_clr, kick, sw_pu;
	logic rst_instr, stk_ovf, stk_unf, prog_exit, wr, rd, ost_req, ce;
	logic [15:0] addr;
	logic [13:0] wdata, rdata, d;
	logic por_req, bor_req, lp_req, lfo, pin, pin_o, pin_oe, pu_en, gpio_in;
	logic sys_rst;
	logic [3:0] freq;
	int failures = 0, n_tests = 0, seed = 96851, kc = 0, n, v;

	reset_source_sequencer #(.POWERUP_DELAY_TIMER_TICKS(4), .WDT_TICKS(8),
		.PART_IDENT(ID_PART), .SILICON_STEP(ID_STEP)) u_reset_source_sequencer (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(ce),
		.por_req_i(por_req), .brown_out_reset_i(bor_req),
		.low_power_brownout_monitor_i(lp_req), .low_freq_internal_osc_i(lfo),
		.ost_required_i(ost_req), .ost_done_i(ost_done),
		.low_power_brownout_cfg_i(lp_cfg), .ext_reset_pin_enable_cfg_i(ext_reset_pin_enable_cfg),
		.low_voltage_program_cfg_i(low_voltage_program_cfg), .stack_fault_reset_enable_i(stk_en),
		.powerup_delay_enable_n_i(powerup_delay_enable_n_n), .watchdog_clear_instr_i(wd_clr),
		.reset_instr_i(rst_instr), .stack_over_i(stk_ovf),
		.stack_under_i(stk_unf), .prog_mode_exit_i(prog_exit),
		.ext_reset_pin_i(pin), .ext_reset_pin_o(pin_o),
		.ext_reset_pin_oe_o(pin_oe), .sw_pullup_en_i(sw_pu),
		.pin_pullup_en_o(pu_en), .gpio_in_o(gpio_in), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.sys_reset_o(sys_rst), .int_osc_freq_select_o(freq));
	supply_pin_model u_supply_pin_model (.ref_clk_i(ref_clk_i),
		.por_cmd_i(por_cmd), .bor_cmd_i(bor_cmd), .low_power_brownout_monitor_cmd_i(lp_cmd),
		.pin_low_cmd_i(pin_low), .pin_drv_i(pin_o), .pin_oe_i(pin_oe),
		.por_req_o(por_req), .brown_out_o(bor_req), .low_power_brownout_monitor_o(lp_req),
		.lfo_o(lfo), .pin_o(pin));

	function automatic logic [13:0] exp_ident();
		return {ID_PART, ID_STEP};
	endfunction
	function automatic logic exp_pin_en(input logic e, input logic l);
		return e | l;
	endfunction

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [13:0] dv);
		@(posedge ref_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= dv;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a);
		@(posedge ref_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Cycles until the internal reset reaches lvl, capped at lim
	task automatic wait_rst(input logic lvl, input int lim);
		n = 0;
		#1;
		while (sys_rst !== lvl && n < lim)
		begin
			@(posedge ref_clk_i);
			#1 n++;
		end
	endtask
	task automatic ev(input int k);
		@(posedge ref_clk_i);
		case (k)
			0: rst_instr <= 1'b1;
			1: stk_ovf <= 1'b1;
			2: stk_unf <= 1'b1;
			default: prog_exit <= 1'b1;
		endcase
		@(posedge ref_clk_i);
		{rst_instr, stk_ovf, stk_unf, prog_exit} <= 4'h0;
	endtask
	task automatic end_test(input string name);
		check(pin_oe === 1'b0 && pin_o === 1'b0, "reset pin driven");
		$display("%s finished at %0t", name, $time);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// Watchdog clears keep the long tests free of timeouts
	always @(posedge ref_clk_i)
	begin
		kc <= kc + 1;
		wd_clr <= kick && (kc % 100 == 0);
	end
	initial
	begin
		#160000;
		failures++;
		end_sim();
	end

	initial
	begin
		{rst_b_i, por_cmd, bor_cmd, lp_cmd, sw_pu} = 5'h00;
		{ost_req, ce} = 2'h3;
		{rst_instr, stk_ovf, stk_unf, prog_exit, wr, rd, low_voltage_program_cfg, stk_en} = 8'h00;
		{pin_low, ext_reset_pin_enable_cfg, lp_cfg, kick, ost_done, powerup_delay_enable_n_n} = 6'h3c;
		addr = 16'h0000;
		wdata = 14'h0000;
		repeat (10) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd_reg(reset_seq_pkg::PART_IDENT_ADDR);
		check(d === exp_ident(), "identity word");
		wr_reg(reset_seq_pkg::PART_IDENT_ADDR, ~exp_ident());
		rd_reg(reset_seq_pkg::PART_IDENT_ADDR);
		check(d === exp_ident(), "identity word written");
		rd_reg(16'h0100);
		check(d === 14'h0000, "unmapped read");
		rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
		check(d[1:0] === 2'b01, "flags after power-on");
		check(freq === reset_seq_pkg::FREQ_SELECT_RST, "freq reset");
		repeat (400) @(posedge ref_clk_i);
		check(sys_rst === 1'b1, "released before oscillator");
		ost_done <= 1'b1;
		repeat (100) @(posedge ref_clk_i);
		check(sys_rst === 1'b1, "released with pin low");
		pin_low <= 1'b0;
		wait_rst(1'b0, 80);
		check(n <= 60, "release after pin high slow");
		end_test("cold start");

		repeat (4)
		begin
			v = $random(seed);
			wr_reg(reset_seq_pkg::OSC_CONTROL_ADDR, {10'h000, v[3:0]});
			check(freq === v[3:0], "freq write");
		end
		ev(0);
		wait_rst(1'b0, 40);
		check(n >= 14 && n <= 18, "warm release time");
		rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
		check(d[reset_seq_pkg::PCS_RI_N] === 1'b0, "instr flag");
		check(freq === 4'h7, "freq after instr");
		wr_reg(reset_seq_pkg::PWR_STATUS_ADDR, 14'h0007);
		end_test("reset instruction");

		for (int k = 0; k < 4; k++)
		begin
			v = $random(seed);
			ext_reset_pin_enable_cfg <= k[1];
			low_voltage_program_cfg <= k[0];
			sw_pu <= v[0];
			pin_low <= 1'b1;
			repeat (70) @(posedge ref_clk_i);
			check(sys_rst === exp_pin_en(k[1], k[0]), "pin cfg");
			check(pu_en === (exp_pin_en(k[1], k[0]) | v[0]), "pull");
			check(gpio_in === 1'b0, "gpio level");
			pin_low <= 1'b0;
			wait_rst(1'b0, 150);
			repeat (60) @(posedge ref_clk_i);
			check(gpio_in === 1'b1, "gpio high");
		end
		{ext_reset_pin_enable_cfg, low_voltage_program_cfg} <= 2'b10;
		repeat (3)
		begin
			v = $random(seed);
			pin_low <= 1'b1;
			repeat (5 + v[4:0] % 30) @(posedge ref_clk_i);
			pin_low <= 1'b0;
			wait_rst(1'b1, 70);
			check(n == 70, "glitch caused reset");
		end
		end_test("reset pin");

		ev(1);
		wait_rst(1'b1, 20);
		check(n == 20, "stack reset while disabled");
		stk_en <= 1'b1;
		ev(2);
		wait_rst(1'b1, 5);
		check(n < 5, "stack reset missing");
		wait_rst(1'b0, 60);
		rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
		check(d[7:6] === 2'b11, "stack flags");
		wr_reg(reset_seq_pkg::PWR_STATUS_ADDR, 14'h0007);
		end_test("stack faults");

		kick <= 1'b0;
		wait_rst(1'b1, 420);
		check(n < 420, "watchdog reset missing");
		rd_reg(reset_seq_pkg::WDT_STATUS_ADDR);
		check(d[1:0] === 2'b01, "watchdog flags");
		kick <= 1'b1;
		wait_rst(1'b0, 60);
		end_test("watchdog");

		lp_cmd <= 1'b1;
		wait_rst(1'b1, 30);
		check(n == 30, "erased monitor acted");
		lp_cmd <= 1'b0;
		// Drain the monitor level from the synchroniser before enabling it
		repeat (4) @(posedge ref_clk_i);
		lp_cfg <= 1'b0;
		for (int s = 0; s < 3; s++)
		begin
			{por_cmd, bor_cmd, lp_cmd} <= 3'b001 << s;
			wait_rst(1'b1, 10);
			check(n < 10, "supply reset missing");
			repeat (100) @(posedge ref_clk_i);
			check(sys_rst === 1'b1, "held while low");
			rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
			check(d[1:0] === ((s == 2) ? 2'b01 : 2'b10), "cause");
			{por_cmd, bor_cmd, lp_cmd} <= 3'b000;
			wait_rst(1'b0, 400);
			check(n >= 60 && n < 400, "power-up delay");
			wr_reg(reset_seq_pkg::PWR_STATUS_ADDR, 14'h0007);
		end
		powerup_delay_enable_n_n <= 1'b1;
		{ost_req, ost_done} <= 2'h0;
		ev(3);
		wait_rst(1'b0, 40);
		check(n >= 14 && n <= 20, "delay not skipped");
		rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
		check(d[1:0] === 2'b01, "programming exit cause");
		end_test("supply and programming exit");

		{ost_req, ost_done} <= 2'h3;
		ce <= 1'b0;
		wr_reg(reset_seq_pkg::OSC_CONTROL_ADDR, 14'h0003);
		ev(0);
		check(freq === 4'h7 && sys_rst === 1'b0, "moved while frozen");
		ce <= 1'b1;
		wr_reg(reset_seq_pkg::OSC_CONTROL_ADDR, 14'h0003);
		check(freq === 4'h3, "freq after thaw");
		end_test("clock enable");

		rst_b_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd_reg(reset_seq_pkg::PWR_STATUS_ADDR);
		check(d[2:0] === 3'h5 && sys_rst === 1'b1, "reset flags");
		check(freq === reset_seq_pkg::FREQ_SELECT_RST, "freq reload");
		wait_rst(1'b0, 60);
		check(n < 60, "release after reset");
		end_test("second reset");
		end_sim();
	end
endmodule
